// ### logic/csb_core_sfr_bank.sv
// core special-function register bank with stack, pointer and status logic
// What this block does
// (RL1) arith_working is operand and result of add, subtract, multiply, divide, bit logic.
// (RL2) multiply_helper joins multiply and divide, otherwise a plain scratch register.
// (RL3) push or call increments stack_top_pointer first, then writes at new address.
// (RL4) reset loads stack_top_pointer with 07H so first stacked byte is at 08H.
// (RL5) data pointer is high and low bytes, usable as 16 bits or two bytes.
// (RL6) cpu_status_word sits at D0H, resets to 00H and allows single-bit access.
// (RL7) status bits 7..0: carry, half carry, flag zero, bank high, bank low, overflow, flag one, parity.
// (RL8) bank select bits pick working bank 0 to 3 by their binary value.
// (RL9) power_control sits at 87H, resets to 00H, no single-bit access.
// (RL10) power bits: baud double, serial wake, ext0 wake, reserved, two flags, deep sleep, halt.
// (RL11) all registers but program counter and banks live in the special-function space.
// (RL12) unoccupied addresses hold no register and read an unspecified value.
// (RL13) software does not touch reserved locations.
// (RL14) registers at addresses ending 0H or 8H allow single-bit addressing.
// (RL15) a read-only byte reports the silicon revision code.
// (RL16) lowest 32 RAM bytes are four banks of eight registers chosen by bank bits.
// (RL17) pop or return reads at stack_top_pointer, then decrements it with 8-bit wrap.
// (RL18) parity bit always equals even-parity indication of arith_working.
`timescale 1ns/10ps
module csb_core_sfr_bank #(
   parameter logic [7:0] REV_CODE = 8'h5A // arbitrary value
) (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   // direct special-function access from the core
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_bit_in, // single-bit access
   input wire logic [2:0] sfr_bitpos_in,
   output logic [7:0] sfr_rdata_out,
   output logic sfr_bit_ok_out, // last bit access was to a bit-addressable register
   // alu result loading
   input wire csb_pkg::csb_op_t alu_op_in,
   input wire logic [7:0] alu_acc_in,
   input wire logic [7:0] alu_mul_in,
   input wire logic alu_cy_in,
   input wire logic alu_ac_in,
   input wire logic alu_ov_in,
   // stack operations
   input wire logic stk_push_in,
   input wire logic stk_pop_in,
   output logic [7:0] stk_addr_out,
   output logic stk_we_out,
   // data pointer as one 16-bit value
   input wire logic data_pointer_pair_wr_in,
   input wire logic data_pointer_pair_inc_in,
   input wire logic [15:0] data_pointer_pair_wdata_in,
   output logic [15:0] data_pointer_pair_out,
   // working register operand to RAM address
   input wire logic [2:0] reg_sel_in,
   output logic [7:0] reg_ram_addr_out,
   // register views to the rest of the chip
   output logic [7:0] arith_working_out,
   output logic [7:0] multiply_helper_out,
   output logic carry_flag_out,
   output logic [1:0] bank_sel_out,
   output logic uart_baud_doubler_out,
   output logic serial_wake_irq_enable_out,
   output logic ext0_wake_irq_enable_out,
   output logic deep_sleep_enable_out,
   output logic core_halt_enable_out
);
   import csb_pkg::*;

   logic [7:0] acc_reg, acc_next;
   logic [7:0] mul_reg, mul_next;
   logic [7:0] sp_reg, sp_next;
   logic [7:0] dph_reg, dph_next;
   logic [7:0] dpl_reg, dpl_next;
   logic [7:0] psw_reg, psw_next;
   logic [7:0] pwr_reg, pwr_next;
   logic [7:0] rdata_reg, rdata_next;
   logic bit_ok_reg;
   logic [7:0] stk_addr_reg, stk_addr_next;
   logic stk_we_reg;
   logic [7:0] reg_addr_reg;

   // address decode
   wire logic hit_acc = sfr_addr_in == CSB_ADDR_ACC;
   wire logic hit_mul = sfr_addr_in == CSB_ADDR_MUL;
   wire logic hit_sp = sfr_addr_in == CSB_ADDR_SP;
   wire logic hit_dph = sfr_addr_in == CSB_ADDR_DPH;
   wire logic hit_dpl = sfr_addr_in == CSB_ADDR_DPL;
   wire logic hit_psw = sfr_addr_in == CSB_ADDR_PSW; // [RL6]
   wire logic hit_pwr = sfr_addr_in == CSB_ADDR_PWR; // [RL9]
   wire logic hit_rev = sfr_addr_in == CSB_ADDR_REV; // [RL15]
   // single-bit access only to addresses ending in 0H or 8H
   wire logic bit_able = (sfr_addr_in[3:0] == CSB_BIT_NIB0) || (sfr_addr_in[3:0] == CSB_BIT_NIB8); // [RL14]
   wire logic wr_ok = sfr_wr_in && (!sfr_bit_in || bit_able); // [RL9] [RL14]

   // current value of the addressed register, unoccupied reads zero
   wire logic [7:0] cur_val =
      hit_acc ? acc_reg :
      hit_mul ? mul_reg :
      hit_sp ? sp_reg :
      hit_dph ? dph_reg :
      hit_dpl ? dpl_reg :
      hit_psw ? psw_reg :
      hit_pwr ? pwr_reg :
      hit_rev ? REV_CODE : CSB_UNMAPPED; // [RL11] [RL12] [RL15]

   // byte write value, or read-modify-write of one bit
   wire logic [7:0] bit_mask = 8'h01 << sfr_bitpos_in;
   wire logic [7:0] wr_val = sfr_bit_in ?
      ((cur_val & ~bit_mask) | (sfr_wdata_in[0] ? bit_mask : 8'h00)) : sfr_wdata_in; // [RL14]

   // stack pointer movement: pre-increment push, post-decrement pop
   wire logic [7:0] sp_inc = sp_reg + 8'h01; // [RL3]
   wire logic [7:0] sp_dec = sp_reg - 8'h01; // [RL17]

   // data pointer as one 16-bit value
   wire logic [15:0] data_pointer_pair_cur = {dph_reg, dpl_reg}; // [RL5]
   wire logic [15:0] data_pointer_pair_inc = data_pointer_pair_cur + 16'h0001;

   // even parity indication of the accumulator
   wire logic acc_par = ^acc_next; // [RL18]

   // working register address: bank times eight plus register
   wire logic [1:0] bank = {psw_next[CSB_PSW_RS1], psw_next[CSB_PSW_RS0]}; // [RL8]
   wire logic [7:0] reg_addr = {3'b000, bank, reg_sel_in}; // [RL16]

   // next-state logic for the accumulator and helper
   always_comb begin
      acc_next = acc_reg;
      mul_next = mul_reg;
      case (alu_op_in)
         CSB_OP_ADD, CSB_OP_SUB, CSB_OP_LOGIC: begin
            acc_next = alu_acc_in; // [RL1]
         end
         CSB_OP_MUL, CSB_OP_DIV: begin
            acc_next = alu_acc_in; // [RL1]
            mul_next = alu_mul_in; // [RL2]
         end
         default: begin
         end
      endcase
      if (wr_ok && hit_acc) begin
         acc_next = wr_val;
      end
      if (wr_ok && hit_mul) begin
         mul_next = wr_val; // [RL2]
      end
   end

   // next-state logic for status word
   always_comb begin
      psw_next = psw_reg;
      if (wr_ok && hit_psw) begin
         psw_next = wr_val; // [RL6]
      end
      case (alu_op_in)
         CSB_OP_ADD, CSB_OP_SUB: begin
            psw_next[CSB_PSW_CY] = alu_cy_in; // [RL7]
            psw_next[CSB_PSW_AC] = alu_ac_in;
            psw_next[CSB_PSW_OV] = alu_ov_in;
         end
         CSB_OP_MUL, CSB_OP_DIV: begin
            psw_next[CSB_PSW_CY] = 1'b0;
            psw_next[CSB_PSW_OV] = alu_ov_in;
         end
         CSB_OP_LOGIC: begin
            psw_next[CSB_PSW_CY] = alu_cy_in;
         end
         default: begin
         end
      endcase
      psw_next[CSB_PSW_P] = acc_par; // [RL18]
   end

   // next-state logic for power control, stack and data pointer
   always_comb begin
      pwr_next = pwr_reg;
      if (wr_ok && hit_pwr && !sfr_bit_in) begin
         pwr_next = sfr_wdata_in & CSB_PWR_WMASK; // [RL9] [RL10]
      end
      sp_next = sp_reg;
      stk_addr_next = stk_addr_reg;
      if (stk_push_in) begin
         sp_next = sp_inc; // [RL3]
         stk_addr_next = sp_inc; // [RL3]
      end else if (stk_pop_in) begin
         sp_next = sp_dec; // [RL17]
         stk_addr_next = sp_reg; // [RL17]
      end else if (wr_ok && hit_sp) begin
         sp_next = wr_val;
      end
      dph_next = dph_reg;
      dpl_next = dpl_reg;
      if (data_pointer_pair_wr_in) begin
         {dph_next, dpl_next} = data_pointer_pair_wdata_in; // [RL5]
      end else if (data_pointer_pair_inc_in) begin
         {dph_next, dpl_next} = data_pointer_pair_inc; // [RL5]
      end else begin
         if (wr_ok && hit_dph) begin
            dph_next = wr_val; // [RL5]
         end
         if (wr_ok && hit_dpl) begin
            dpl_next = wr_val; // [RL5]
         end
      end
      rdata_next = sfr_rd_in ? cur_val : rdata_reg; // [RL12]
   end

   // register state
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         acc_reg <= CSB_RST_ZERO;
         mul_reg <= CSB_RST_ZERO;
         sp_reg <= CSB_RST_SP; // [RL4]
         dph_reg <= CSB_RST_ZERO;
         dpl_reg <= CSB_RST_ZERO;
         psw_reg <= CSB_RST_PSW; // [RL6]
         pwr_reg <= CSB_RST_PWR; // [RL9]
         rdata_reg <= CSB_RST_ZERO;
         bit_ok_reg <= 1'b0;
         stk_addr_reg <= CSB_RST_ZERO;
         stk_we_reg <= 1'b0;
         reg_addr_reg <= CSB_RST_ZERO;
      end else begin
         acc_reg <= acc_next;
         mul_reg <= mul_next;
         sp_reg <= sp_next;
         dph_reg <= dph_next;
         dpl_reg <= dpl_next;
         psw_reg <= psw_next;
         pwr_reg <= pwr_next;
         rdata_reg <= rdata_next;
         if (sfr_bit_in && (sfr_wr_in || sfr_rd_in)) begin
            bit_ok_reg <= bit_able; // [RL14]
         end
         stk_addr_reg <= stk_addr_next;
         stk_we_reg <= stk_push_in; // [RL3]
         reg_addr_reg <= reg_addr; // [RL16]
      end
   end

   // outputs straight from flip-flops
   assign sfr_rdata_out = rdata_reg;
   assign sfr_bit_ok_out = bit_ok_reg;
   assign stk_addr_out = stk_addr_reg;
   assign stk_we_out = stk_we_reg;
   assign data_pointer_pair_out = {dph_reg, dpl_reg};
   assign reg_ram_addr_out = reg_addr_reg;
   assign arith_working_out = acc_reg;
   assign multiply_helper_out = mul_reg;
   assign carry_flag_out = psw_reg[CSB_PSW_CY];
   assign bank_sel_out = {psw_reg[CSB_PSW_RS1], psw_reg[CSB_PSW_RS0]};
   assign uart_baud_doubler_out = pwr_reg[CSB_PWR_BAUD2];
   assign serial_wake_irq_enable_out = pwr_reg[CSB_PWR_SERWK];
   assign ext0_wake_irq_enable_out = pwr_reg[CSB_PWR_EXTWK];
   assign deep_sleep_enable_out = pwr_reg[CSB_PWR_DEEP];
   assign core_halt_enable_out = pwr_reg[CSB_PWR_HALT];
endmodule : csb_core_sfr_bank

// ### pkg/csb_pkg.sv
// constants for the core special-function register bank
package csb_pkg;
   // special-function addresses of the core registers
   localparam logic [7:0] CSB_ADDR_PWR = 8'h87; // power_control
   localparam logic [7:0] CSB_ADDR_SP = 8'h81; // stack_top_pointer
   localparam logic [7:0] CSB_ADDR_DPL = 8'h82; // data_pointer_low
   localparam logic [7:0] CSB_ADDR_DPH = 8'h83; // data_pointer_high
   localparam logic [7:0] CSB_ADDR_PSW = 8'hD0; // cpu_status_word
   localparam logic [7:0] CSB_ADDR_ACC = 8'hE0; // arith_working
   localparam logic [7:0] CSB_ADDR_MUL = 8'hF0; // multiply_helper
   localparam logic [7:0] CSB_ADDR_REV = 8'hFE; // silicon_revision_code
   // reset values
   localparam logic [7:0] CSB_RST_PWR = 8'h00;
   localparam logic [7:0] CSB_RST_PSW = 8'h00;
   localparam logic [7:0] CSB_RST_SP = 8'h07;
   localparam logic [7:0] CSB_RST_ZERO = 8'h00;
   // fields of the status word
   localparam int CSB_PSW_CY = 7;
   localparam int CSB_PSW_AC = 6;
   localparam int CSB_PSW_F0 = 5;
   localparam int CSB_PSW_RS1 = 4;
   localparam int CSB_PSW_RS0 = 3;
   localparam int CSB_PSW_OV = 2;
   localparam int CSB_PSW_F1 = 1;
   localparam int CSB_PSW_P = 0;
   // fields of the power control register
   localparam int CSB_PWR_BAUD2 = 7;
   localparam int CSB_PWR_SERWK = 6;
   localparam int CSB_PWR_EXTWK = 5;
   localparam int CSB_PWR_RSVD = 4;
   localparam int CSB_PWR_GFH = 3;
   localparam int CSB_PWR_GFL = 2;
   localparam int CSB_PWR_DEEP = 1;
   localparam int CSB_PWR_HALT = 0;
   localparam logic [7:0] CSB_PWR_WMASK = 8'hEF; // reserved bit stays zero
   // working register banks: four banks of eight
   localparam int CSB_BANK_REGS = 8;
   // bit-addressable addresses end in this low nibble or the next
   localparam logic [3:0] CSB_BIT_NIB0 = 4'h0;
   localparam logic [3:0] CSB_BIT_NIB8 = 4'h8;
   // value returned for unoccupied addresses
   localparam logic [7:0] CSB_UNMAPPED = 8'h00;
   // alu operation codes from the core
   typedef enum logic [2:0] {CSB_OP_NONE, CSB_OP_ADD, CSB_OP_SUB, CSB_OP_MUL, CSB_OP_DIV, CSB_OP_LOGIC} csb_op_t;
endpackage : csb_pkg

// ### tb/csb_sfr_monitor.sv
// assertion checker for the core register bank ports
`timescale 1ns/10ps
module csb_sfr_monitor (
   input wire logic ref_clk_in,
   input wire logic resetn_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic sfr_bit_in,
   input wire logic [7:0] sfr_rdata_out,
   input wire logic sfr_bit_ok_out,
   input wire logic stk_push_in,
   input wire logic stk_pop_in,
   input wire logic [7:0] stk_addr_out,
   input wire logic stk_we_out,
   input wire logic [2:0] reg_sel_in,
   input wire logic [7:0] reg_ram_addr_out,
   input wire logic [7:0] arith_working_out,
   input wire logic [1:0] bank_sel_out,
   input wire logic uart_baud_doubler_out,
   input wire logic core_halt_enable_out
);
   // all checks share the core clock and its reset
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   AST_PUSH_WE: assert property (stk_push_in |=> stk_we_out)
      else $error("no stack write after push");
   AST_NO_WE: assert property (!stk_push_in |=> !stk_we_out)
      else $error("stack write without push");
   AST_PUSH_INC: assert property (stk_push_in ##1 stk_push_in |=> stk_addr_out == $past(stk_addr_out) + 8'h01)
      else $error("push address not one above");
   AST_POP_DEC: assert property (stk_pop_in && !stk_push_in ##1 stk_pop_in && !stk_push_in
      |=> stk_addr_out == $past(stk_addr_out) - 8'h01)
      else $error("pop address not one below");
   AST_PARITY: assert property (sfr_rd_in && sfr_addr_in == 8'hD0
      |=> sfr_rdata_out[0] == ^$past(arith_working_out))
      else $error("parity bit wrong");
   AST_BANK_ADDR: assert property (resetn_in |=> reg_ram_addr_out == {3'h0, bank_sel_out, $past(reg_sel_in)})
      else $error("working register address wrong");
   AST_BIT_OK: assert property ((sfr_rd_in || sfr_wr_in) && sfr_bit_in
      |=> sfr_bit_ok_out == ($past(sfr_addr_in[2:0]) == 3'h0))
      else $error("bit access flag wrong");
   AST_PWR_NOBIT: assert property (sfr_wr_in && sfr_bit_in && sfr_addr_in == 8'h87
      |=> $stable({uart_baud_doubler_out, core_halt_enable_out}))
      else $error("power bits changed by bit write");
endmodule : csb_sfr_monitor

bind csb_core_sfr_bank csb_sfr_monitor csb_sfr_monitor_i (.*);

// ### tb/tb.sv
// self-checking testbench for the core register bank
`timescale 1ns/10ps
module tb;
   import csb_pkg::*;
   localparam logic [7:0] REV = 8'h3C; // arbitrary revision value
   // probed addresses are mapped or unoccupied, never reserved ones
   localparam logic [7:0] RA [9] = '{8'h87, 8'hD0, 8'h81, 8'h82, 8'h83, 8'hE0, 8'hF0, 8'hFE, 8'h90};
   localparam logic [7:0] RE [9] = '{8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, REV, 8'h00};
   logic ref_clk_in = 1'b0, resetn_in = 1'b0, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, sfr_bit_in = 1'b0;
   logic stk_push_in = 1'b0, stk_pop_in = 1'b0, data_pointer_pair_wr_in = 1'b0, data_pointer_pair_inc_in = 1'b0;
   logic alu_cy_in = 1'b1, alu_ac_in = 1'b1, alu_ov_in = 1'b1;
   logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, alu_acc_in = 8'h00, alu_mul_in = 8'h00;
   logic [2:0] sfr_bitpos_in = 3'h0, reg_sel_in = 3'h0;
   logic [15:0] data_pointer_pair_wdata_in = 16'h0000;
   csb_op_t alu_op_in = CSB_OP_NONE;
   logic [7:0] sfr_rdata_out, stk_addr_out, reg_ram_addr_out, arith_working_out, multiply_helper_out, exp_mul;
   logic [15:0] data_pointer_pair_out;
   logic [1:0] bank_sel_out;
   logic sfr_bit_ok_out, stk_we_out, carry_flag_out, uart_baud_doubler_out, serial_wake_irq_enable_out;
   logic ext0_wake_irq_enable_out, deep_sleep_enable_out, core_halt_enable_out;
   int fail_count = 0, n_checks = 0;
   csb_core_sfr_bank #(.REV_CODE(REV)) csb_core_sfr_bank_i (.*);
   // 25 MHz core clock
   always #20 ref_clk_in = ~ref_clk_in;
   // compare and count
   task chk(input string nm, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one access cycle; outputs are settled on return
   task op(input logic w, r, b, input logic [7:0] a, d);
      sfr_wr_in = w;
      sfr_rd_in = r;
      sfr_bit_in = b;
      sfr_addr_in = a;
      sfr_wdata_in = d;
      @(posedge ref_clk_in);
      #1;
   endtask : op
   task nop;
      op(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
   endtask : nop
   task rdc(input logic [7:0] a, exp);
      op(1'b0, 1'b1, 1'b0, a, 8'h00);
      chk($sformatf("read %h", a), sfr_rdata_out, exp);
   endtask : rdc
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   // hang guard
   initial begin
      #200000;
      fail_count++;
      end_sim;
   end
   // main sequence
   initial begin
      repeat (12) @(posedge ref_clk_in);
      #1;
      resetn_in = 1'b1;
      foreach (RA[i]) rdc(RA[i], RE[i]);
      op(1'b1, 1'b0, 1'b0, 8'hFE, 8'h00);
      rdc(8'hFE, REV);
      stk_push_in = 1'b1;
      nop;
      chk("stack addr", stk_addr_out, 16'h0008);
      chk("stack we", stk_we_out, 16'h0001);
      nop;
      stk_push_in = 1'b0;
      stk_pop_in = 1'b1;
      nop;
      chk("pop addr", stk_addr_out, 16'h0009);
      chk("pop we", stk_we_out, 16'h0000);
      nop;
      stk_pop_in = 1'b0;
      rdc(8'h81, 8'h07);
      op(1'b1, 1'b0, 1'b0, 8'h81, 8'h00);
      stk_pop_in = 1'b1;
      nop;
      stk_pop_in = 1'b0;
      rdc(8'h81, 8'hFF);
      reg_sel_in = 3'h5;
      for (int b = 0; b < 4; b++) begin
         op(1'b1, 1'b0, 1'b0, 8'hD0, 8'(b << 3));
         chk("bank", bank_sel_out, 16'(b));
         chk("reg addr", reg_ram_addr_out, 16'(b * 8 + 5));
      end
      op(1'b1, 1'b0, 1'b0, 8'hD0, 8'hA6);
      rdc(8'hD0, 8'hA6);
      chk("carry", carry_flag_out, 16'h0001);
      op(1'b1, 1'b0, 1'b0, 8'hE0, 8'h07);
      rdc(8'hD0, 8'hA7);
      sfr_bitpos_in = 3'h5;
      op(1'b1, 1'b0, 1'b1, 8'hD0, 8'h00);
      chk("bit ok", sfr_bit_ok_out, 16'h0001);
      rdc(8'hD0, 8'h87);
      op(1'b1, 1'b0, 1'b0, 8'h87, 8'hFF);
      chk("power", {uart_baud_doubler_out, serial_wake_irq_enable_out, ext0_wake_irq_enable_out,
         deep_sleep_enable_out, core_halt_enable_out}, 16'h001F);
      rdc(8'h87, 8'hEF);
      op(1'b1, 1'b0, 1'b1, 8'h87, 8'h00);
      chk("bit ok", sfr_bit_ok_out, 16'h0000);
      rdc(8'h87, 8'hEF);
      op(1'b1, 1'b0, 1'b0, 8'h87, 8'h02);
      chk("power", {uart_baud_doubler_out, deep_sleep_enable_out, core_halt_enable_out}, 16'h0002);
      op(1'b1, 1'b0, 1'b0, 8'hF0, 8'h55);
      rdc(8'hF0, 8'h55);
      exp_mul = 8'h55;
      for (int i = 1; i < 6; i++) begin
         alu_op_in = csb_op_t'(i);
         alu_acc_in = 8'(8'h10 + i);
         alu_mul_in = 8'(8'h20 + i);
         nop;
         if (i == 3 || i == 4) exp_mul = alu_mul_in;
         chk("acc", arith_working_out, alu_acc_in);
         chk("helper", multiply_helper_out, exp_mul);
         chk("alu carry", carry_flag_out, 16'(i != 3 && i != 4));
      end
      alu_op_in = CSB_OP_NONE;
      rdc(8'hD0, 8'hC7);
      data_pointer_pair_wdata_in = 16'h12FF;
      data_pointer_pair_wr_in = 1'b1;
      nop;
      data_pointer_pair_wr_in = 1'b0;
      data_pointer_pair_inc_in = 1'b1;
      nop;
      data_pointer_pair_inc_in = 1'b0;
      chk("pointer", data_pointer_pair_out, 16'h1300);
      rdc(8'h83, 8'h13);
      op(1'b1, 1'b0, 1'b0, 8'h82, 8'h5A);
      chk("pointer", data_pointer_pair_out, 16'h135A);
      end_sim;
   end
endmodule : tb
